/* File: ubtdr_map.svh */
/*
  register offsets, field positions, reset values and counts of the serial channel
  assumes inclusion by every design file that decodes or resets these registers
*/
`ifndef UBTDR_MAP_SVH
`define UBTDR_MAP_SVH

// --------------------
// byte offsets
// --------------------
`define UBTDR_OFS_THR   8'h00
`define UBTDR_OFS_BAUD  8'h04
`define UBTDR_OFS_RTO   8'h08
`define UBTDR_OFS_TTG   8'h0c
`define UBTDR_OFS_RPTR  8'h10
`define UBTDR_OFS_RCNT  8'h14
`define UBTDR_OFS_TPTR  8'h18
`define UBTDR_OFS_TCNT  8'h1c
`define UBTDR_OFS_MODE  8'h20
`define UBTDR_OFS_STAT  8'h24

// --------------------
// fields
// --------------------
`define UBTDR_MODE_SYNC    0
`define UBTDR_MODE_CLK_LO  1
`define UBTDR_MODE_CLK_HI  2
`define UBTDR_MODE_LEN_LO  3
`define UBTDR_MODE_LEN_HI  4
`define UBTDR_STAT_TX_READY_FLAG   0
`define UBTDR_STAT_TXEMPTY 1
`define UBTDR_STAT_TIMEOUT 2
`define UBTDR_STAT_ENDRX   3
`define UBTDR_STAT_ENDTX   4

// --------------------
// reset values and counts
// --------------------
`define UBTDR_RST_DIV    16'h0000
`define UBTDR_RST_BYTE   8'h00
`define UBTDR_RST_MODE   5'h18
`define UBTDR_RST_WORD   32'h0000_0000
`define UBTDR_RST_CNT    16'h0000
`define UBTDR_PRE_LAST   3'h7
`define UBTDR_OS_LAST    4'hf
`define UBTDR_TO_SHIFT   2
`define UBTDR_LEN_BASE   4'h5
`define UBTDR_RESP_OKAY  2'b00
`define UBTDR_RESP_SLV   2'b10

`endif

/* File: ubtdr_pkg.sv */
/*
  types of the serial channel block
  assumes the map header for all numeric constants
*/
package ubtdr_pkg;

  typedef enum logic [2:0]
  {
    tx_idle  = 3'b000,
    tx_start = 3'b001,
    tx_data  = 3'b011,
    tx_stop  = 3'b010,
    tx_guard = 3'b110
  } ubtdr_tx_state_t;

  typedef enum logic [1:0]
  {
    clk_sys  = 2'b00,
    clk_div8 = 2'b01,
    clk_ext  = 2'b10,
    clk_ext2 = 2'b11
  } ubtdr_clk_sel_t;

endpackage

/* File: ubtdr_baud.sv */
/*
  baud generator: one bit_tick pulse per bit period
  assumes sel_tick and ext_tick are one-cycle pulses on aclk
*/
`timescale 1ns/100ps
`default_nettype none
`include "ubtdr_map.svh"

module ubtdr_baud
#(
  parameter int DIV_W = 16
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             cen,
  input  wire logic             sel_tick,
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic             sync_mode,
  input  wire logic             ext_sync,
  input  wire logic             ext_tick,
  output var  logic             bit_tick
);

  logic [DIV_W-1:0] div_cnt_r, div_cnt_nxt;
  logic [3:0]       os_cnt_r, os_cnt_nxt;
  logic             tick_nxt;
  logic             pulse;

  // --------------------
  // division
  // --------------------
  always_comb
  begin
    div_cnt_nxt = div_cnt_r;
    os_cnt_nxt  = os_cnt_r;
    pulse       = 1'b0;
    tick_nxt    = 1'b0;
    if (ext_sync)
    begin
      tick_nxt = ext_tick; // [R5]
    end
    else if (divisor != '0 && sel_tick) // [R3]
    begin
      if (div_cnt_r >= divisor - DIV_W'(1))
      begin
        div_cnt_nxt = '0;
        pulse       = 1'b1;
      end
      else
      begin
        div_cnt_nxt = div_cnt_r + DIV_W'(1);
      end
    end
    if (!ext_sync && pulse)
    begin
      if (sync_mode)
      begin
        tick_nxt = 1'b1; // [R4]
      end
      else
      begin
        os_cnt_nxt = os_cnt_r + 4'h1; // [R3]
        tick_nxt   = (os_cnt_r == `UBTDR_OS_LAST);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt_r <= '0;
      os_cnt_r  <= 4'h0;
      bit_tick  <= 1'b0;
    end
    else if (cen)
    begin
      div_cnt_r <= div_cnt_nxt;
      os_cnt_r  <= os_cnt_nxt;
      bit_tick  <= tick_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: ubtdr_timeout.sv */
/*
  receive time-out counter and its sticky flag
  assumes start and char_rx are one-cycle pulses, bit_tick one per bit period
*/
`timescale 1ns/100ps
`default_nettype none
`include "ubtdr_map.svh"

module ubtdr_timeout
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       cen,
  input  wire logic       start,
  input  wire logic       char_rx,
  input  wire logic       bit_tick,
  input  wire logic [7:0] value,
  output var  logic       flag
);

  logic [9:0] cnt_r, cnt_nxt;
  logic       run_r, run_nxt;
  logic       flag_nxt;

  function automatic logic [9:0] load_of(input logic [7:0] v);
    load_of = {v, 2'b00};
  endfunction

  // --------------------
  // counting
  // --------------------
  always_comb
  begin
    cnt_nxt  = cnt_r;
    run_nxt  = run_r;
    flag_nxt = flag;
    if (start)
    begin
      cnt_nxt  = load_of(value); // [R8] [R10]
      run_nxt  = 1'b0;
      flag_nxt = 1'b0;
    end
    else if (char_rx && value != 8'h00)
    begin
      cnt_nxt = load_of(value); // [R10]
      run_nxt = 1'b1;
    end
    else if (run_r && bit_tick && cnt_r != 10'h000)
    begin
      cnt_nxt = cnt_r - 10'h001; // [R11]
      if (cnt_r == 10'h001)
      begin
        run_nxt  = 1'b0;
        flag_nxt = 1'b1; // [R20]
      end
    end
    if (value == 8'h00)
    begin
      run_nxt  = 1'b0; // [R9]
      flag_nxt = 1'b0; // [R20]
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= 10'h000;
      run_r <= 1'b0;
      flag  <= 1'b0;
    end
    else if (cen)
    begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      flag  <= flag_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: ubtdr_top.sv */
/*
  serial channel registers: holding, divisor, time-out, guard, transfer channels
  assumes an AXI4-Lite master, a receiver and a memory port outside
*/
// Our own choices: the register addresses and the AXI4-Lite register port.
// Operation
// [R1] holding write queues next transmitted character
// [R2] short characters use right-aligned low bits
// [R3] divisor: zero stops, one bypasses, else sixteen times; asynchronous mode here also divides by sixteen for one
// [R4] synchronous mode divides by divisor only
// [R5] synchronous external clock ignores divisor
// [R6] software avoids bypass with system clock
// [R7] software uses even divisor when synchronous
// [R8] time-out write restarts time-out
// [R9] zero time-out disables time-out
// [R10] counter reloads on start and each character
// [R11] time-out lasts value times four bits
// [R12] zero guard allows back to back
// [R13] line held high after each character
// [R14] guard lasts value bit periods
// [R15] software loads receive pointer before transfer
// [R16] software loads receive count with size
// [R17] receive count zero stops receive transfers
// [R18] software loads transmit pointer before transfer
// [R19] transmit count zero stops transmit transfers
// [R20] time-out flag set on expiry, clear if zero
// [R21] each byte advances pointer, counts down, ends
`timescale 1ns/100ps
`default_nettype none
`include "ubtdr_map.svh"

module ubtdr_top
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              cen,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output var  logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  input  wire logic              ext_clk,
  input  wire logic              rx_char_done,
  input  wire logic              rx_ready_flag,
  output var  logic              rx_xfer_req,
  output var  logic [31:0]       rx_xfer_addr,
  input  wire logic              rx_xfer_ack,
  output var  logic              tx_xfer_req,
  output var  logic [31:0]       tx_xfer_addr,
  input  wire logic              tx_xfer_ack,
  input  wire logic [7:0]        tx_xfer_data,
  output var  logic              txd,
  output var  logic              tx_ready_flag,
  output var  logic              tx_empty,
  output var  logic              timeout_flag,
  output var  logic              end_rx,
  output var  logic              end_tx,
  output var  ubtdr_pkg::ubtdr_tx_state_t tx_state
);
  import ubtdr_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) && (a <= ADDR_W'(`UBTDR_OFS_STAT));
  endfunction

  function automatic logic [7:0] len_mask(input logic [1:0] len);
    return 8'hff >> (2'd3 - len);
  endfunction

  // --------------------
  // bus slave
  // --------------------
  logic              aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]       wdata_r, wdata_nxt;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic              bvalid_nxt, rvalid_nxt;
  logic [1:0]        bresp_nxt, rresp_nxt;
  logic [31:0]       rdata_nxt;
  logic              wr_go;
  logic [31:0]       rd_word;

  always_comb
  begin
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    rvalid_nxt  = s_axi_rvalid;
    rresp_nxt   = s_axi_rresp;
    rdata_nxt   = s_axi_rdata;
    wr_go       = aw_have_r && w_have_r && !s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (wr_go)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = is_mapped(awaddr_r) ? `UBTDR_RESP_OKAY : `UBTDR_RESP_SLV;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_word;
      rresp_nxt  = is_mapped(s_axi_araddr) ? `UBTDR_RESP_OKAY : `UBTDR_RESP_SLV;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= `UBTDR_RST_WORD;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UBTDR_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `UBTDR_RESP_OKAY;
      s_axi_rdata   <= `UBTDR_RST_WORD;
    end
    else if (cen)
    begin
      aw_have_r     <= aw_have_nxt;
      w_have_r      <= w_have_nxt;
      awaddr_r      <= awaddr_nxt;
      wdata_r       <= wdata_nxt;
      wstrb_r       <= wstrb_nxt;
      s_axi_awready <= !aw_have_nxt && !bvalid_nxt;
      s_axi_wready  <= !w_have_nxt && !bvalid_nxt;
      s_axi_arready <= !rvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rresp   <= rresp_nxt;
      s_axi_rdata   <= rdata_nxt;
    end
  end

  // --------------------
  // registers, transfer channels, transmitter
  // --------------------
  logic [15:0]     div_r, div_nxt, rcnt_r, rcnt_nxt, tcnt_r, tcnt_nxt;
  logic [7:0]      to_r, to_nxt, tg_r, tg_nxt, hold_r, hold_nxt, shift_r, shift_nxt;
  logic [7:0]      gcnt_r, gcnt_nxt;
  logic [31:0]     rptr_r, rptr_nxt, tptr_r, tptr_nxt, wv;
  logic [4:0]      mode_r, mode_nxt;
  logic [3:0]      bits_r, bits_nxt;
  logic [2:0]      pre_r, pre_nxt;
  logic            full_r, full_nxt, rreq_nxt, treq_nxt, txd_nxt, ext_prev_r;
  logic            start_r, start_nxt, sel_tick, ext_edge, bit_tick, launch;
  ubtdr_tx_state_t st_nxt;
  ubtdr_clk_sel_t  clk_sel;

  assign clk_sel  = ubtdr_clk_sel_t'(mode_r[`UBTDR_MODE_CLK_HI:`UBTDR_MODE_CLK_LO]);
  assign ext_edge = ext_clk && !ext_prev_r;

  always_comb
  begin
    case (clk_sel)
      clk_sys:  sel_tick = 1'b1;
      clk_div8: sel_tick = (pre_r == `UBTDR_PRE_LAST);
      default:  sel_tick = ext_edge;
    endcase
    case (awaddr_r)
      `UBTDR_OFS_BAUD: wv = merge({16'h0000, div_r}, wdata_r, wstrb_r);
      `UBTDR_OFS_RTO:  wv = merge({24'h000000, to_r}, wdata_r, wstrb_r);
      `UBTDR_OFS_TTG:  wv = merge({24'h000000, tg_r}, wdata_r, wstrb_r);
      `UBTDR_OFS_RPTR: wv = merge(rptr_r, wdata_r, wstrb_r);
      `UBTDR_OFS_RCNT: wv = merge({16'h0000, rcnt_r}, wdata_r, wstrb_r);
      `UBTDR_OFS_TPTR: wv = merge(tptr_r, wdata_r, wstrb_r);
      `UBTDR_OFS_TCNT: wv = merge({16'h0000, tcnt_r}, wdata_r, wstrb_r);
      `UBTDR_OFS_MODE: wv = merge({27'h0, mode_r}, wdata_r, wstrb_r);
      default:         wv = merge(32'h0000_0000, wdata_r, wstrb_r);
    endcase
    case (s_axi_araddr)
      `UBTDR_OFS_BAUD: rd_word = {16'h0000, div_r};
      `UBTDR_OFS_RTO:  rd_word = {24'h000000, to_r};
      `UBTDR_OFS_TTG:  rd_word = {24'h000000, tg_r};
      `UBTDR_OFS_RPTR: rd_word = rptr_r;
      `UBTDR_OFS_RCNT: rd_word = {16'h0000, rcnt_r};
      `UBTDR_OFS_TPTR: rd_word = tptr_r;
      `UBTDR_OFS_TCNT: rd_word = {16'h0000, tcnt_r};
      `UBTDR_OFS_MODE: rd_word = {27'h0, mode_r};
      `UBTDR_OFS_STAT: rd_word = {27'h0, end_tx, end_rx, timeout_flag, tx_empty, tx_ready_flag};
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    {div_nxt, to_nxt, tg_nxt, mode_nxt} = {div_r, to_r, tg_r, mode_r};
    {rptr_nxt, rcnt_nxt, tptr_nxt, tcnt_nxt} = {rptr_r, rcnt_r, tptr_r, tcnt_r};
    {hold_nxt, full_nxt, shift_nxt, bits_nxt} = {hold_r, full_r, shift_r, bits_r};
    {gcnt_nxt, st_nxt, txd_nxt} = {gcnt_r, tx_state, txd};
    rreq_nxt  = rx_xfer_req;
    treq_nxt  = tx_xfer_req;
    start_nxt = 1'b0;
    pre_nxt   = pre_r + 3'h1;
    launch    = bit_tick && full_r && (tx_state == tx_idle ||
                (tx_state == tx_stop && tg_r == 8'h00) ||
                (tx_state == tx_guard && gcnt_r == 8'h01));
    if (launch)
    begin
      full_nxt  = 1'b0;
      shift_nxt = hold_r;
      txd_nxt   = 1'b0;
      st_nxt    = tx_start; // [R1] [R12]
    end
    else if (bit_tick)
    begin
      case (tx_state)
        tx_start:
        begin
          txd_nxt   = shift_r[0];
          shift_nxt = shift_r >> 1;
          bits_nxt  = `UBTDR_LEN_BASE + {2'b00, mode_r[`UBTDR_MODE_LEN_HI:`UBTDR_MODE_LEN_LO]};
          st_nxt    = tx_data;
        end
        tx_data:
        begin
          bits_nxt  = bits_r - 4'h1;
          txd_nxt   = (bits_r == 4'h1) ? 1'b1 : shift_r[0];
          shift_nxt = shift_r >> 1;
          st_nxt    = (bits_r == 4'h1) ? tx_stop : tx_data;
        end
        tx_stop:
        begin
          gcnt_nxt = tg_r; // [R13] [R14]
          st_nxt   = (tg_r == 8'h00) ? tx_idle : tx_guard;
        end
        tx_guard:
        begin
          gcnt_nxt = gcnt_r - 8'h01; // [R14]
          txd_nxt  = 1'b1; // [R13]
          st_nxt   = (gcnt_r == 8'h01) ? tx_idle : tx_guard;
        end
        default:
        begin
          txd_nxt = 1'b1;
          st_nxt  = tx_idle;
        end
      endcase
    end
    if (rx_xfer_req && rx_xfer_ack)
    begin
      rptr_nxt = rptr_r + 32'h1; // [R21]
      rcnt_nxt = rcnt_r - 16'h1;
      rreq_nxt = 1'b0;
    end
    else if (!rx_xfer_req && rcnt_r != 16'h0000 && rx_ready_flag)
    begin
      rreq_nxt = 1'b1; // [R17]
    end
    if (tx_xfer_req && tx_xfer_ack)
    begin
      tptr_nxt = tptr_r + 32'h1; // [R21]
      tcnt_nxt = tcnt_r - 16'h1;
      treq_nxt = 1'b0;
      hold_nxt = tx_xfer_data & len_mask(mode_r[`UBTDR_MODE_LEN_HI:`UBTDR_MODE_LEN_LO]);
      full_nxt = 1'b1;
    end
    else if (!tx_xfer_req && tcnt_r != 16'h0000 && !full_r)
    begin
      treq_nxt = 1'b1; // [R19]
    end
    if (wr_go)
    begin
      case (awaddr_r)
        `UBTDR_OFS_THR:
        begin
          hold_nxt = wv[7:0] & len_mask(mode_r[`UBTDR_MODE_LEN_HI:`UBTDR_MODE_LEN_LO]); // [R2]
          full_nxt = 1'b1; // [R1]
        end
        `UBTDR_OFS_BAUD: div_nxt = wv[15:0];
        `UBTDR_OFS_RTO:
        begin
          to_nxt    = wv[7:0];
          start_nxt = 1'b1; // [R8]
        end
        `UBTDR_OFS_TTG:  tg_nxt = wv[7:0];
        `UBTDR_OFS_RPTR: rptr_nxt = wv;
        `UBTDR_OFS_RCNT: rcnt_nxt = wv[15:0];
        `UBTDR_OFS_TPTR: tptr_nxt = wv;
        `UBTDR_OFS_TCNT: tcnt_nxt = wv[15:0];
        `UBTDR_OFS_MODE: mode_nxt = wv[4:0];
        default:         ;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {div_r, to_r, tg_r} <= {`UBTDR_RST_DIV, `UBTDR_RST_BYTE, `UBTDR_RST_BYTE};
      mode_r        <= `UBTDR_RST_MODE;
      {rptr_r, tptr_r} <= {`UBTDR_RST_WORD, `UBTDR_RST_WORD};
      {rcnt_r, tcnt_r} <= {`UBTDR_RST_CNT, `UBTDR_RST_CNT};
      {hold_r, shift_r, gcnt_r} <= {`UBTDR_RST_BYTE, `UBTDR_RST_BYTE, `UBTDR_RST_BYTE};
      full_r        <= 1'b0;
      bits_r        <= 4'h0;
      pre_r         <= 3'h0;
      ext_prev_r    <= 1'b0;
      start_r       <= 1'b0;
      tx_state      <= tx_idle;
      txd           <= 1'b1;
      rx_xfer_req   <= 1'b0;
      tx_xfer_req   <= 1'b0;
      rx_xfer_addr  <= `UBTDR_RST_WORD;
      tx_xfer_addr  <= `UBTDR_RST_WORD;
      tx_ready_flag <= 1'b1;
      tx_empty      <= 1'b1;
      end_rx        <= 1'b1;
      end_tx        <= 1'b1;
    end
    else if (cen)
    begin
      {div_r, to_r, tg_r, mode_r} <= {div_nxt, to_nxt, tg_nxt, mode_nxt};
      {rptr_r, rcnt_r, tptr_r, tcnt_r} <= {rptr_nxt, rcnt_nxt, tptr_nxt, tcnt_nxt};
      {hold_r, full_r, shift_r, bits_r} <= {hold_nxt, full_nxt, shift_nxt, bits_nxt};
      gcnt_r        <= gcnt_nxt;
      pre_r         <= pre_nxt;
      ext_prev_r    <= ext_clk;
      start_r       <= start_nxt;
      tx_state      <= st_nxt;
      txd           <= txd_nxt;
      rx_xfer_req   <= rreq_nxt;
      tx_xfer_req   <= treq_nxt;
      rx_xfer_addr  <= rptr_nxt;
      tx_xfer_addr  <= tptr_nxt;
      tx_ready_flag <= !full_nxt;
      tx_empty      <= !full_nxt && st_nxt == tx_idle;
      end_rx        <= (rcnt_nxt == 16'h0000); // [R21]
      end_tx        <= (tcnt_nxt == 16'h0000);
    end
  end

  // --------------------
  // baud clock and time-out
  // --------------------
  ubtdr_baud u_baud
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .cen       (cen),
    .sel_tick  (sel_tick),
    .divisor   (div_r),
    .sync_mode (mode_r[`UBTDR_MODE_SYNC]),
    .ext_sync  (mode_r[`UBTDR_MODE_SYNC] && mode_r[`UBTDR_MODE_CLK_HI]),
    .ext_tick  (ext_edge),
    .bit_tick  (bit_tick)
  );

  ubtdr_timeout u_timeout
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .cen      (cen),
    .start    (start_r),
    .char_rx  (rx_char_done),
    .bit_tick (bit_tick),
    .value    (to_r),
    .flag     (timeout_flag)
  );

endmodule
`default_nettype wire

/* File: ubtdr_top_asserts.sv */
/*
  port checker of the serial channel block
  assumes a bind to ubtdr_top and a running clock enable
*/
`timescale 1ns/100ps
`default_nettype none
module ubtdr_top_asserts
(
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       cen,
  input wire logic                       rx_xfer_req,
  input wire logic [31:0]                rx_xfer_addr,
  input wire logic                       rx_xfer_ack,
  input wire logic                       tx_xfer_req,
  input wire logic [31:0]                tx_xfer_addr,
  input wire logic                       tx_xfer_ack,
  input wire logic                       txd,
  input wire logic                       end_rx,
  input wire logic                       end_tx,
  input wire ubtdr_pkg::ubtdr_tx_state_t tx_state
);
  import ubtdr_pkg::*;
  // --------------------
  // checks
  // --------------------
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !cen);
  chk_rx_stop: assert property (end_rx |-> !rx_xfer_req)
    else $error("rx request at zero count");
  chk_tx_stop: assert property (end_tx |-> !tx_xfer_req)
    else $error("tx request at zero count");
  chk_rx_step: assert property (rx_xfer_req && rx_xfer_ack |=>
    !rx_xfer_req && rx_xfer_addr == $past(rx_xfer_addr) + 32'h1)
    else $error("rx pointer step wrong");
  chk_tx_step: assert property (tx_xfer_req && tx_xfer_ack |=>
    !tx_xfer_req && tx_xfer_addr == $past(tx_xfer_addr) + 32'h1)
    else $error("tx pointer step wrong");
  chk_rx_hold: assert property (rx_xfer_req && !rx_xfer_ack |=>
    rx_xfer_req && $stable(rx_xfer_addr))
    else $error("rx request dropped");
  chk_tx_hold: assert property (tx_xfer_req && !tx_xfer_ack |=>
    tx_xfer_req && $stable(tx_xfer_addr))
    else $error("tx request dropped");
  chk_guard_high: assert property (tx_state == tx_guard && $past(tx_state) == tx_guard |-> txd)
    else $error("line low in guard");
  chk_start_low: assert property (tx_state == tx_start && $past(tx_state) == tx_start |-> !txd)
    else $error("start bit not low");
  cov_rx_ack: cover property (rx_xfer_req && rx_xfer_ack);
  cov_tx_ack: cover property (tx_xfer_req && tx_xfer_ack);
  cov_guard: cover property (tx_state == tx_guard);
endmodule
bind ubtdr_top ubtdr_top_asserts i_ubtdr_top_asserts (.aclk, .aresetn, .cen, .rx_xfer_req,
  .rx_xfer_addr, .rx_xfer_ack, .tx_xfer_req, .tx_xfer_addr, .tx_xfer_ack, .txd, .end_rx,
  .end_tx, .tx_state);
`default_nettype wire

/* File: ubtdr_xfer_model.sv */
/*
  memory side of both transfer channels
  assumes requests stand until acknowledged
*/
`timescale 1ns/100ps
`default_nettype none
module ubtdr_xfer_model
(
  input  wire logic        aclk,
  input  wire logic [3:0]  lag,
  input  wire logic        rx_xfer_req,
  output var  logic        rx_xfer_ack,
  input  wire logic        tx_xfer_req,
  input  wire logic [31:0] tx_xfer_addr,
  output var  logic        tx_xfer_ack,
  output var  logic [7:0]  tx_xfer_data
);
  logic [3:0] rw = 4'h0;
  logic [3:0] tw = 4'h0;
  // --------------------
  // answer after lag cycles
  // --------------------
  initial
  begin
    rx_xfer_ack = 1'b0;
    tx_xfer_ack = 1'b0;
    tx_xfer_data = 8'h00;
  end
  always @(posedge aclk)
  begin
    rx_xfer_ack <= 1'b0;
    tx_xfer_ack <= 1'b0;
    tx_xfer_data <= ~tx_xfer_data;
    rw <= (rx_xfer_req && !rx_xfer_ack) ? rw + 4'h1 : 4'h0;
    tw <= (tx_xfer_req && !tx_xfer_ack) ? tw + 4'h1 : 4'h0;
    if (rx_xfer_req && !rx_xfer_ack && rw >= lag)
      rx_xfer_ack <= 1'b1;
    if (tx_xfer_req && !tx_xfer_ack && tw >= lag)
    begin
      tx_xfer_ack <= 1'b1;
      tx_xfer_data <= tx_xfer_addr[7:0] ^ 8'h5a;
    end
  end
endmodule
`default_nettype wire

/* File: ubtdr_top_tb.sv */
/*
  register and line tests of the serial channel
  assumes the transfer model on the memory side
*/
`timescale 1ns/100ps
`default_nettype none
module ubtdr_top_tb;
  logic        aclk, aresetn, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic        ext, chd, rxf, rq, ra, tq, ta, txd, te, erx, tof;
  logic [7:0]  aa, td;
  logic [31:0] wd, rdat, txa;
  logic [1:0]  bs, rs;
  logic [3:0]  lag;
  logic [31:0] msk [7] = '{32'h0, 32'hffff, 32'hff, 32'hff, 32'hffff_ffff, 32'hffff,
                           32'hffff_ffff};
  int          error_cnt = 0, n_tests = 0, cyc = 0;

  ubtdr_top i_ubtdr_top
  (
    .aclk, .aresetn, .cen(1'b1), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(aa), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bs),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(aa), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rs), .ext_clk(ext),
    .rx_char_done(chd), .rx_ready_flag(rxf), .rx_xfer_req(rq), .rx_xfer_addr(),
    .rx_xfer_ack(ra), .tx_xfer_req(tq), .tx_xfer_addr(txa), .tx_xfer_ack(ta),
    .tx_xfer_data(td), .txd, .tx_ready_flag(), .tx_empty(te), .timeout_flag(tof),
    .end_rx(erx), .end_tx(), .tx_state()
  );
  ubtdr_xfer_model i_ubtdr_xfer_model
  (
    .aclk, .lag, .rx_xfer_req(rq), .rx_xfer_ack(ra), .tx_xfer_req(tq),
    .tx_xfer_addr(txa), .tx_xfer_ack(ta), .tx_xfer_data(td)
  );
  // --------------------
  // clocks and tasks
  // --------------------
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    ext <= (cyc % 6) < 3;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic pa, pw;
    @(posedge aclk);
    awv <= 1'b1;
    wv <= 1'b1;
    aa <= a;
    wd <= d;
    {pa, pw} = 2'b11;
    do
    begin
      @(posedge aclk);
      if (pa && awr) awv <= 1'b0;
      if (pw && wrdy) wv <= 1'b0;
      pa = pa && !awr;
      pw = pw && !wrdy;
    end
    while (pa || pw);
    br <= 1'b1;
    do @(posedge aclk); while (bv !== 1'b1);
    br <= 1'b0;
    chk({30'h0, bs}, {30'h0, e});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] es);
    @(posedge aclk);
    arv <= 1'b1;
    aa <= a;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    rr <= 1'b1;
    do @(posedge aclk); while (rv !== 1'b1);
    rr <= 1'b0;
    chk(rdat, e);
    chk({30'h0, rs}, {30'h0, es});
  endtask
  task pul(input int n);
    repeat (n) @(posedge aclk);
    chd <= 1'b1;
    @(posedge aclk);
    chd <= 1'b0;
  endtask
  task frame(input logic [31:0] m, input logic [31:0] g, input logic [31:0] dv, input int bc);
    logic [7:0] c, d;
    int t0;
    wr(8'h20, m, 2'b00);
    wr(8'h0c, g, 2'b00);
    wr(8'h04, dv, 2'b00);
    wr(8'h18, 32'h40, 2'b00);
    wr(8'h1c, 32'h2, 2'b00);
    for (int k = 0; k < 2; k++)
    begin
      do @(posedge aclk); while (txd !== 1'b0);
      if (k == 1) chk(cyc - t0, (7 + g) * bc);
      t0 = cyc;
      for (int b = 0; b < 7; b++)
      begin
        c = {txd, c[7:1]};
        if (b < 6) repeat (bc) @(posedge aclk);
      end
      d = (8'h40 + 8'(k)) ^ 8'h5a;
      chk({25'h0, c[7:1]}, {25'h0, 1'b1, d[4:0], 1'b0});
    end
    do @(posedge aclk); while (te !== 1'b1);
    rd(8'h18, 32'h42, 2'b00);
    rd(8'h1c, 32'h0, 2'b00);
  endtask
  task finish_test;
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // --------------------
  // tests
  // --------------------
  initial
  begin
    {aresetn, awv, wv, br, arv, rr, ext, chd, rxf} = '0;
    {aa, wd, lag} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0, 2'b00);
    rd(8'h24, 32'h1b, 2'b00);
    rd(8'h28, 32'h0, 2'b10);
    wr(8'h28, 32'h1, 2'b10);
    wr(8'h05, 32'h1, 2'b10);
    for (int i = 1; i < 7; i++)
    begin
      wr(8'(4 * i), 32'hffff_ffff, 2'b00);
      rd(8'(4 * i), msk[i], 2'b00);
    end
    wr(8'h10, 32'h100, 2'b00);
    wr(8'h14, 32'h3, 2'b00);
    rxf <= 1'b1;
    repeat (2) @(posedge aclk);
    do @(posedge aclk); while (erx !== 1'b1);
    rd(8'h10, 32'h103, 2'b00);
    rd(8'h14, 32'h0, 2'b00);
    rxf <= 1'b0;
    wr(8'h20, 32'h0, 2'b00);
    wr(8'h04, 32'h2, 2'b00);
    wr(8'h08, 32'h2, 2'b00);
    pul(0);
    pul(200);
    repeat (180) @(posedge aclk);
    chk({31'h0, tof}, 32'h0);
    repeat (150) @(posedge aclk);
    chk({31'h0, tof}, 32'h1);
    wr(8'h08, 32'h2, 2'b00);
    repeat (2) @(posedge aclk);
    chk({31'h0, tof}, 32'h0);
    wr(8'h08, 32'h0, 2'b00);
    pul(0);
    repeat (400) @(posedge aclk);
    chk({31'h0, tof}, 32'h0);
    lag <= 4'h3;
    frame(32'h0, 32'h0, 32'h3, 48);
    frame(32'h0, 32'h3, 32'h3, 48);
    frame(32'h1, 32'h1, 32'h2, 2);
    frame(32'h5, 32'h0, 32'h9, 6);
    finish_test;
  end
  initial
  begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    finish_test;
  end
endmodule
`default_nettype wire
